// ===== ccrs_board.sv
// Purpose: board reset driver and pll clock level source
// Assumes: hold is driven by the bench
// Notes:   pll level toggles every two reference cycles
module ccrs_board (
	input  wire logic clk,
	input  wire logic hold,
	output logic      rstn,
	output logic      pll_clock_level
);
	// ----
	// board
	// ----
	logic half_ff = 1'b0;
	logic test_clk_low = 1'b0;
	initial pll_clock_level = 1'b0;
	assign rstn = ~hold;
	// free running, never halted or slowed
	always @(posedge clk) begin
		half_ff <= ~half_ff;
		if (half_ff)
			pll_clock_level <= ~pll_clock_level;
	end
endmodule

// ===== ccrs_lock_timer.sv
// Purpose: counts reference cycles while the pll settles
// Assumes: start held high for the whole wait
// Notes:   done is a level that stays high until start drops
module ccrs_lock_timer (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic start,
	output logic      done
);

	// ------------------------------------------------------------
	// counter
	// ------------------------------------------------------------
	logic [ccrs_pkg::LOCK_W-1:0] cnt_ff;
	logic [ccrs_pkg::LOCK_W-1:0] nxt_cnt;
	localparam logic [ccrs_pkg::LOCK_W-1:0] LAST =
		ccrs_pkg::LOCK_W'(ccrs_pkg::LOCK_CYCLES - 1);

	always_comb begin
		if (!start)
			nxt_cnt = '0;
		else if (cnt_ff != LAST)
			nxt_cnt = cnt_ff + 1'b1;
		else
			nxt_cnt = cnt_ff;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			cnt_ff <= '0;
		else
			cnt_ff <= nxt_cnt;
	end

	assign done = start && (cnt_ff == LAST);

endmodule

// ===== ccrs_pkg.sv
// Purpose: shared constants and types for the core clock/reset sequencer
// Assumes: one 25 MHz reference clock, plain register port
// Notes:   register offsets and field positions are local choices
package ccrs_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned LOCK_CYCLES = 4096;
	localparam int unsigned LOCK_W      = 13;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_POWER_MGMT_CONTROL_REG  = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;

	localparam int unsigned MULT_LSB   = 0;
	localparam int unsigned MULT_W     = 5;
	localparam int unsigned DIV_LSB    = 5;
	localparam int unsigned DIV_W      = 3;
	localparam int unsigned BYPASS_BIT = 8;
	localparam int unsigned OUTSEL_BIT = 12;

	localparam int unsigned ST_STRAP_LSB = 0;
	localparam int unsigned ST_RUN_BIT   = 2;
	localparam int unsigned ST_SW_BIT    = 3;

	// ------------------------------------------------------------
	// strap encodings and derived settings
	// ------------------------------------------------------------
	localparam logic [1:0] STRAP_X3  = 2'h0;
	localparam logic [1:0] STRAP_X16 = 2'h1;
	localparam logic [1:0] STRAP_X8  = 2'h2;
	localparam logic [1:0] STRAP_RSV = 2'h3;

	localparam logic [MULT_W-1:0] MULT_X3  = 5'h03;
	localparam logic [MULT_W-1:0] MULT_X16 = 5'h10;
	localparam logic [MULT_W-1:0] MULT_X8  = 5'h08;
	localparam logic [MULT_W-1:0] MULT_X1  = 5'h01;
	localparam logic [DIV_W-1:0]  DIV_RST  = 3'h1;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SEQ_RESET = 2'b00,
		SEQ_LOCK  = 2'b01,
		SEQ_RUN   = 2'b10
	} ccrs_seq_t;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} ccrs_bus_req_t;

	typedef struct packed {
		logic [MULT_W-1:0] mult;
		logic [DIV_W-1:0]  div;
		logic              bypass;
	} ccrs_clk_cfg_t;

endpackage

// ===== ccrs_top.sv
// Purpose: core clock and reset sequencing with strap-selected ratio
// Assumes: ref clock is clk; pll itself lives outside, this steers it
// Notes:   registers on a plain port, read data one cycle after rd
module ccrs_top (
	input  wire logic                    clk,
	input  wire logic                    rstn,
	input  wire ccrs_pkg::ccrs_bus_req_t bus_req,
	output logic [31:0]                  bus_rdata,
	input  wire logic [1:0]              ratio_strap_pins,
	input  wire logic                    pll_clock_level,
	output ccrs_pkg::ccrs_clk_cfg_t      core_clk_cfg,
	output logic                         core_reset_n,
	output logic                         reset_or_clock_output
);

	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	// power-up reset is held by the board, so this always starts clean
	// only the second stage is read; the first may be metastable
	logic rst_meta_ff;
	logic rst_n_ff;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta_ff <= 1'b0;
			rst_n_ff    <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n_ff    <= rst_meta_ff;
		end
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	ccrs_pkg::ccrs_seq_t seq_ff;
	ccrs_pkg::ccrs_seq_t nxt_seq;
	logic                lock_done;

	// counter relies on a free-running, steady reference clock
	ccrs_lock_timer u_lock (
		.clk   (clk),
		.rst_n (rst_n_ff),
		.start (seq_ff == ccrs_pkg::SEQ_LOCK),
		.done  (lock_done)
	);

	// run is terminal: only a fresh reset restarts the lock wait
	always_comb begin
		nxt_seq = seq_ff;
		unique case (seq_ff)
			ccrs_pkg::SEQ_RESET: begin
				nxt_seq = ccrs_pkg::SEQ_LOCK;
			end
			ccrs_pkg::SEQ_LOCK: begin
				if (lock_done)
					nxt_seq = ccrs_pkg::SEQ_RUN;
			end
			ccrs_pkg::SEQ_RUN: begin
				nxt_seq = ccrs_pkg::SEQ_RUN;
			end
			default: begin
				nxt_seq = ccrs_pkg::SEQ_RESET;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff)
			seq_ff <= ccrs_pkg::SEQ_RESET;
		else
			seq_ff <= nxt_seq;
	end

	logic running;
	assign running = (seq_ff == ccrs_pkg::SEQ_RUN);

	// ------------------------------------------------------------
	// strap capture
	// ------------------------------------------------------------
	// async reset may only load constants, so sampling waits for release
	// a strap change once the core runs waits for the next reset
	logic [1:0] strap_ff;

	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff)
			strap_ff <= ccrs_pkg::STRAP_X3;
		else if (!running)
			strap_ff <= ratio_strap_pins;
	end

	// ------------------------------------------------------------
	// control register
	// ------------------------------------------------------------
	logic                              wr_power_mgmt_control_reg;
	logic                              sw_prog_ff;
	logic [ccrs_pkg::MULT_W-1:0]       mult_ff;
	logic [ccrs_pkg::DIV_W-1:0]        div_ff;
	logic                              bypass_ff;
	logic                              outsel_ff;
	logic [ccrs_pkg::MULT_W-1:0]       strap_mult;
	logic                              strap_bypass;

	// writes before the core runs are dropped: pll is still locking
	assign wr_power_mgmt_control_reg = bus_req.wr && running &&
		(bus_req.addr == ccrs_pkg::OFS_POWER_MGMT_CONTROL_REG);

	always_comb begin
		strap_mult   = ccrs_pkg::MULT_X1;
		strap_bypass = 1'b0;
		unique case (strap_ff)
			ccrs_pkg::STRAP_X3:  strap_mult = ccrs_pkg::MULT_X3;
			ccrs_pkg::STRAP_X16: strap_mult = ccrs_pkg::MULT_X16;
			ccrs_pkg::STRAP_X8:  strap_mult = ccrs_pkg::MULT_X8;
			ccrs_pkg::STRAP_RSV: begin
				// reserved code: run straight off the reference
				strap_mult   = ccrs_pkg::MULT_X1;
				strap_bypass = 1'b1;
			end
		endcase
	end

	// sticky: once software owns the pll settings the straps stop steering
	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff)
			sw_prog_ff <= 1'b0;
		else if (wr_power_mgmt_control_reg)
			sw_prog_ff <= 1'b1;
	end

	// a write replaces all fields at once, so no half-set ratio is seen
	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			mult_ff   <= ccrs_pkg::MULT_X3;
			div_ff    <= ccrs_pkg::DIV_RST;
			bypass_ff <= 1'b0;
		end else if (wr_power_mgmt_control_reg) begin
			mult_ff   <= bus_req.wdata[ccrs_pkg::MULT_LSB +:
				ccrs_pkg::MULT_W];
			div_ff    <= bus_req.wdata[ccrs_pkg::DIV_LSB +:
				ccrs_pkg::DIV_W];
			bypass_ff <= bus_req.wdata[ccrs_pkg::BYPASS_BIT];
		end else if (!sw_prog_ff) begin
			mult_ff   <= strap_mult;
			div_ff    <= ccrs_pkg::DIV_RST;
			bypass_ff <= strap_bypass;
		end
	end

	// reset-out by default, so a part on the pin is held with the core
	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff)
			outsel_ff <= 1'b0;
		else if (wr_power_mgmt_control_reg)
			outsel_ff <= bus_req.wdata[ccrs_pkg::OUTSEL_BIT];
	end

	// ------------------------------------------------------------
	// core side outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff)
			core_reset_n <= 1'b0;
		else
			core_reset_n <= running;
	end

	assign core_clk_cfg.mult   = mult_ff;
	assign core_clk_cfg.div    = div_ff;
	assign core_clk_cfg.bypass = bypass_ff;

	// pin and core reset come from one state, so they never skew
	// shared pin: clock mode only mirrors the pll level, one cycle late
	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff)
			reset_or_clock_output <= 1'b0;
		else if (outsel_ff)
			reset_or_clock_output <= pll_clock_level;
		else
			reset_or_clock_output <= running;
	end

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	// unmapped addresses read as zero
	// read data stands one cycle, then drops back to zero
	logic [31:0] rd_word;

	always_comb begin
		rd_word = '0;
		if (bus_req.addr == ccrs_pkg::OFS_POWER_MGMT_CONTROL_REG) begin
			rd_word[ccrs_pkg::MULT_LSB +: ccrs_pkg::MULT_W] = mult_ff;
			rd_word[ccrs_pkg::DIV_LSB +: ccrs_pkg::DIV_W]   = div_ff;
			rd_word[ccrs_pkg::BYPASS_BIT] = bypass_ff;
			rd_word[ccrs_pkg::OUTSEL_BIT] = outsel_ff;
		end else if (bus_req.addr == ccrs_pkg::OFS_STATUS) begin
			rd_word[ccrs_pkg::ST_STRAP_LSB +: $bits(strap_ff)] = strap_ff;
			rd_word[ccrs_pkg::ST_RUN_BIT]        = running;
			rd_word[ccrs_pkg::ST_SW_BIT]         = sw_prog_ff;
		end
	end

	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff)
			bus_rdata <= '0;
		else if (bus_req.rd)
			bus_rdata <= rd_word;
		else
			bus_rdata <= '0;
	end

endmodule

// ===== ccrs_top_assertions.sv
// Purpose: port checks for the clock and reset sequencer
// Assumes: one clock, raw rstn as disable
// Notes:   clock mode shows the pll level exactly one cycle late
module ccrs_top_chk (
	input wire logic                    clk,
	input wire logic                    rstn,
	input wire ccrs_pkg::ccrs_bus_req_t bus_req,
	input wire logic [31:0]             bus_rdata,
	input wire logic [1:0]              ratio_strap_pins,
	input wire logic                    pll_clock_level,
	input wire ccrs_pkg::ccrs_clk_cfg_t core_clk_cfg,
	input wire logic                    core_reset_n,
	input wire logic                    reset_or_clock_output
);
	// ----
	// helpers
	// ----
	logic [12:0] low_ff;
	logic        sel_ff;
	logic [8:0]  cfg_tab [4] = '{9'h032, 9'h102, 9'h082, 9'h013};
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// saturates so a stuck reset cannot wrap into the window
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			low_ff <= 13'h0;
		else if (!core_reset_n && low_ff != 13'h1fff)
			low_ff <= low_ff + 13'h1;
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			sel_ff <= 1'b0;
		else if (bus_req.wr && bus_req.addr == 8'h00 && core_reset_n)
			sel_ff <= bus_req.wdata[12];
	end
	// ----
	// checks
	// ----
	rdata_idle_a: assert property (
		!$past(bus_req.rd) |-> bus_rdata == 32'h0) else $error("stray rdata");
	lock_delay_a: assert property (
		$rose(core_reset_n) |-> low_ff >= 13'h1000 && low_ff <= 13'h1010)
		else $error("lock wait wrong");
	rst_mirror_a: assert property (
		!sel_ff && !$past(sel_ff) |-> reset_or_clock_output == core_reset_n)
		else $error("pin not reset");
	pin_low_a: assert property (
		!core_reset_n |-> !reset_or_clock_output) else $error("pin high");
	clk_mode_a: assert property (
		sel_ff && $past(sel_ff) |->
		reset_or_clock_output == $past(pll_clock_level))
		else $error("pin not pll");
	strap_cfg_a: assert property (
		!core_reset_n && low_ff >= 13'h5 && $stable(ratio_strap_pins) &&
		ratio_strap_pins == $past(ratio_strap_pins, 2) |->
		core_clk_cfg == cfg_tab[ratio_strap_pins]) else $error("bad ratio");
	cfg_frozen_a: assert property (
		core_reset_n && $past(core_reset_n) && !$past(bus_req.wr) |->
		$stable(core_clk_cfg)) else $error("cfg moved");
	wr_apply_a: assert property (
		core_reset_n && bus_req.wr && bus_req.addr == 8'h00 |=>
		core_clk_cfg.mult == $past(bus_req.wdata[4:0]) &&
		core_clk_cfg.div == $past(bus_req.wdata[7:5]) &&
		core_clk_cfg.bypass == $past(bus_req.wdata[8]))
		else $error("write lost");
endmodule
bind ccrs_top ccrs_top_chk u_chk (.clk(clk), .rstn(rstn),
	.bus_req(bus_req), .bus_rdata(bus_rdata),
	.ratio_strap_pins(ratio_strap_pins), .pll_clock_level(pll_clock_level),
	.core_clk_cfg(core_clk_cfg), .core_reset_n(core_reset_n),
	.reset_or_clock_output(reset_or_clock_output));

// ===== tb.sv
// Purpose: self-checking bench for the sequencer
// Assumes: 25 MHz reference, full 4096 lock wait
// Notes:   strap rows run during the lock wait
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic                    clk = 1'b0;
	logic                    hold = 1'b1;
	logic                    rstn;
	logic                    pll;
	ccrs_pkg::ccrs_bus_req_t req = '0;
	logic [1:0]              strap = 2'h0;
	logic [31:0]             rdata;
	ccrs_pkg::ccrs_clk_cfg_t cfg;
	logic                    crst_n;
	logic                    pin;
	int                      n_fail = 0;
	int                      num_checks = 0;
	int                      cyc = 0;
	int                      t0;
	int                      i;
	logic [8:0]              tab [4] = '{9'h032, 9'h102, 9'h082, 9'h013};
	logic [1:0]              rows [4] = '{2'h0, 2'h3, 2'h2, 2'h1};
	always #20 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	ccrs_board u_ccrs_board (.clk(clk), .hold(hold), .rstn(rstn),
		.pll_clock_level(pll));
	ccrs_top u_ccrs_top (.clk(clk), .rstn(rstn), .bus_req(req),
		.bus_rdata(rdata), .ratio_strap_pins(strap), .pll_clock_level(pll),
		.core_clk_cfg(cfg), .core_reset_n(crst_n),
		.reset_or_clock_output(pin));
	// ----
	// tasks
	// ----
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		req.wr <= 1'b1;
		req.addr <= a;
		req.wdata <= d;
		@(posedge clk);
		req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		req.rd <= 1'b1;
		req.addr <= a;
		@(posedge clk);
		req.rd <= 1'b0;
		#1;
		chk(rdata, e, "read data");
	endtask
	task automatic print_verdict();
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ----
	// sequence
	// ----
	initial begin
		repeat (2) @(posedge clk);
		hold <= 1'b0;
		#1 t0 = cyc;
		for (i = 0; i < 4; i++) begin
			@(posedge clk);
			strap <= rows[i];
			repeat (4) @(posedge clk);
			#1;
			chk({23'h0, cfg}, {23'h0, tab[rows[i]]}, "ratio");
			chk({31'h0, pin}, 32'h0, "pin in lock");
		end
		$display("test straps done");
		i = 0;
		while (crst_n !== 1'b1 && i < 5000) begin
			@(posedge clk);
			#1 i++;
		end
		chk(cyc - t0, ccrs_pkg::LOCK_CYCLES + 32'd4, "lock delay");
		if (i == 5000) begin
			n_fail++;
			print_verdict();
		end
		chk({31'h0, pin}, 32'h1, "pin release");
		@(posedge clk);
		strap <= 2'h2;
		repeat (4) @(posedge clk);
		#1;
		chk({23'h0, cfg}, {23'h0, tab[1]}, "frozen");
		rd(8'h04, 32'h5);
		wr(8'h00, 32'h14a);
		rd(8'h00, 32'h14a);
		chk({23'h0, cfg}, 32'ha5, "new pll cfg");
		rd(8'h04, 32'hd);
		rd(8'h08, 32'h0);
		$display("test registers done");
		wr(8'h00, 32'h114a);
		t0 = 0;
		repeat (8) begin
			@(posedge clk);
			#1 t0 += int'(pin === 1'b0);
		end
		chk(t0, 32'd4, "clock on pin");
		wr(8'h00, 32'h14a);
		@(posedge clk);
		#1 chk({31'h0, pin}, 32'h1, "reset on pin");
		$display("test shared pin done");
		@(posedge clk);
		hold <= 1'b1;
		#1 chk({21'h0, cfg, pin, crst_n}, 32'hc8, "async reset");
		repeat (2) @(posedge clk);
		hold <= 1'b0;
		repeat (4) @(posedge clk);
		wr(8'h00, 32'h114a);
		repeat (3) @(posedge clk);
		#1 chk({22'h0, cfg, pin}, {22'h0, tab[2], 1'b0}, "early wr");
		rd(8'h04, 32'h2);
		$display("test second reset done");
		print_verdict();
	end
endmodule
